// ### design/osc_ctl.sv
// Purpose: register block for oscillator, trim, watchdog enable and
//          clock fail interrupt, reached over AHB-Lite
// Assumes: single word transfers, hready of the bus is our hreadyout
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.

// Summary of operation
// - clock fail flag set on monitor failure
// - bit 1 turns secondary oscillator on/off
// - bit 0 starts switch, clears when done
// - six-bit trim is signed frequency offset
// - trim upper bits read zero, resets zero
// - writing one starts watchdog if boot didn't
// - writing zero stops only software watchdog
// - enable bit reads one while watchdog runs
// - enabled watchdog turns on low-power RC
// - interrupt flag bit 14 set on failure
// - enable bit 14 gates fail interrupt
// - priority 12:10, code zero disables interrupt
// - subpriority 9:8 equals its binary value
// - new source field selects eight sources
// - lock with monitor blocks selection changes
module osc_ctl
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  // boot configuration straps
  input  wire osc_ctl_pkg::boot_cfg_s   boot_cfg,
  // oscillator and monitor side
  input  wire logic                     clock_fail_detect,
  input  wire logic                     osc_ack,
  output osc_ctl_pkg::osc_drive_s       osc_drive,
  output osc_ctl_pkg::clk_source_e      current_source,
  // watchdog side
  output logic                          watchdog_run,
  output logic                          watchdog_restart,
  // interrupt
  output logic                          irq,
  output logic [2:0]                    irq_priority,
  output logic [1:0]                    irq_subpriority
);

  ////////////////////////////////////////////////////////////////////////////
  // bus pipeline state
  logic                                 dp_valid;   // data phase pending
  logic                                 dp_write;   // data phase is a write
  logic [osc_ctl_pkg::ADDR_BITS-1:0]    dp_addr;    // latched byte address
  logic                                 rd_done;    // read data loaded
  logic                                 wr_en;      // write strobe
  logic [31:0]                          read_word;  // read mux output

  // held configuration, sampled during reset
  logic                                 monitor_armed;  // monitor enabled
  logic                                 boot_watchdog;  // watchdog by boot

  // oscillator_control state
  logic                                 switch_req;     // request pending
  logic                                 sec_osc_en;     // secondary enable
  logic                                 clock_fail;     // failure seen
  logic                                 clock_lock;     // lock bit
  osc_ctl_pkg::clk_source_e             new_source;     // requested source
  osc_ctl_pkg::clk_source_e             next_new_source;  // field after this edge
  logic                                 locked;         // writes blocked

  // other registers
  logic [osc_ctl_pkg::TRIM_BITS-1:0]    trim;           // fast RC trim
  logic                                 soft_watchdog;  // watchdog by software
  logic                                 fail_irq_flag;  // sticky flag
  logic                                 fail_irq_en;    // mask
  logic [osc_ctl_pkg::PRIO_BITS-1:0]    prio;           // priority code
  logic [osc_ctl_pkg::SUBPRIO_BITS-1:0] subprio;        // subpriority code

  // switch sequencer handshake
  logic                                 switch_start;   // launch a switch
  logic                                 switch_busy;    // switch in flight
  logic                                 switch_done;    // switch completed
  osc_ctl_pkg::clk_source_e             mux_select;     // source to the mux

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture; taken only while the bus is ready
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= '0;
    end
    else if (hready)
    begin
      dp_valid <= hsel & htrans[1];  // nonseq or seq only
      dp_write <= hwrite;
      dp_addr  <= haddr[osc_ctl_pkg::ADDR_BITS-1:0];
    end
  end

  // one wait state on reads so the data comes from a flip-flop and
  // always reflects any write that completed just before
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_done <= 1'b0;
    else if (hready)
      rd_done <= 1'b0;                         // transfer finished
    else if (dp_valid && !dp_write)
      rd_done <= 1'b1;                         // data loaded this edge
  end

  // registered read data
  always_ff @(posedge clk)
  begin
    if (rst)
      hrdata <= '0;
    else if (dp_valid && !dp_write && !rd_done)
      hrdata <= read_word;
  end

  assign hreadyout = !(dp_valid && !dp_write && !rd_done);
  assign hresp     = 1'b0;                     // always OKAY
  assign wr_en     = dp_valid && dp_write;     // zero wait write

  ////////////////////////////////////////////////////////////////////////////
  // straps are sampled while the synchronous reset is held
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      monitor_armed <= boot_cfg.fail_monitor_enable;
      boot_watchdog <= boot_cfg.watchdog_enable;
    end
  end

  // selection lock only bites while the monitor is armed
  assign locked = monitor_armed && clock_lock;

  ////////////////////////////////////////////////////////////////////////////
  // secondary oscillator enable and clock lock bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sec_osc_en <= 1'b0;
      clock_lock <= 1'b0;
    end
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_OSC_CONTROL)
    begin
      sec_osc_en <= hwdata[osc_ctl_pkg::BIT_SEC_OSC_EN];
      clock_lock <= hwdata[osc_ctl_pkg::BIT_CLOCK_LOCK];
      // bit 2 is never stored, so a stray one cannot stick
    end
  end

  // value the field takes at this edge; the sequencer latches the same
  // value, so setting the field and the request in one write switches to
  // the new code rather than the old one
  always_comb
  begin
    next_new_source = new_source;
    if (wr_en && dp_addr == osc_ctl_pkg::OFS_OSC_CONTROL && !locked)
      next_new_source = osc_ctl_pkg::clk_source_e'(
        hwdata[osc_ctl_pkg::NEW_SRC_LSB +: osc_ctl_pkg::SRC_BITS]);
  end

  // new source field, frozen while locked
  always_ff @(posedge clk)
  begin
    if (rst)
      new_source <= boot_cfg.source;
    else
      new_source <= next_new_source;
  end

  // switch request: set by software, returned to zero by hardware
  assign switch_start = wr_en && dp_addr == osc_ctl_pkg::OFS_OSC_CONTROL
                        && hwdata[osc_ctl_pkg::BIT_SWITCH_REQ] && !locked
                        && !switch_busy;

  always_ff @(posedge clk)
  begin
    if (rst)
      switch_req <= 1'b0;
    else if (switch_start)
      switch_req <= 1'b1;
    else if (switch_done)
      switch_req <= 1'b0;
  end

  // clock fail status: hardware set wins over a software write of zero
  always_ff @(posedge clk)
  begin
    if (rst)
      clock_fail <= 1'b0;
    else if (clock_fail_detect)
      clock_fail <= 1'b1;
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_OSC_CONTROL)
      clock_fail <= clock_fail && hwdata[osc_ctl_pkg::BIT_CLOCK_FAIL];  // only clears
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast RC trim, passed straight to the oscillator as a signed offset
  always_ff @(posedge clk)
  begin
    if (rst)
      trim <= osc_ctl_pkg::TRIM_RESET;
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_FAST_RC_TUNE)
      trim <= hwdata[osc_ctl_pkg::TRIM_BITS-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // software watchdog enable; a boot enable cannot be undone here
  always_ff @(posedge clk)
  begin
    if (rst)
      soft_watchdog <= 1'b0;
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_WATCHDOG_CTL)
      soft_watchdog <= hwdata[osc_ctl_pkg::BIT_WATCHDOG_ON];
  end

  // kick pulse; nothing is stored, so the bit always reads back zero
  always_ff @(posedge clk)
  begin
    if (rst)
      watchdog_restart <= 1'b0;
    else
      watchdog_restart <= wr_en && dp_addr == osc_ctl_pkg::OFS_WATCHDOG_CTL
                          && hwdata[osc_ctl_pkg::BIT_KICK];
  end

  assign watchdog_run = boot_watchdog || soft_watchdog;

  ////////////////////////////////////////////////////////////////////////////
  // sticky fail interrupt flag, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (rst)
      fail_irq_flag <= 1'b0;
    else if (clock_fail_detect)
      fail_irq_flag <= 1'b1;
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_IRQ_FLAGS
             && hwdata[osc_ctl_pkg::BIT_FAIL_IRQ])
      fail_irq_flag <= 1'b0;
  end

  // interrupt mask
  always_ff @(posedge clk)
  begin
    if (rst)
      fail_irq_en <= 1'b0;
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_IRQ_ENABLES)
      fail_irq_en <= hwdata[osc_ctl_pkg::BIT_FAIL_IRQ];
  end

  // priority and subpriority fields
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prio    <= '0;
      subprio <= '0;
    end
    else if (wr_en && dp_addr == osc_ctl_pkg::OFS_IRQ_PRIORITY)
    begin
      prio    <= hwdata[osc_ctl_pkg::PRIO_LSB +: osc_ctl_pkg::PRIO_BITS];
      subprio <= hwdata[osc_ctl_pkg::SUBPRIO_LSB +: osc_ctl_pkg::SUBPRIO_BITS];
    end
  end

  // level interrupt; a zero priority code keeps it quiet even when enabled
  assign irq             = fail_irq_flag && fail_irq_en
                           && prio != osc_ctl_pkg::PRIO_OFF;
  assign irq_priority    = prio;
  assign irq_subpriority = subprio;

  ////////////////////////////////////////////////////////////////////////////
  // drive to the oscillators; the watchdog needs its RC clock running
  assign osc_drive.secondary_osc_enable = sec_osc_en;
  assign osc_drive.low_power_rc_enable  = watchdog_run;
  assign osc_drive.select               = mux_select;
  assign osc_drive.fast_rc_trim         = trim;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unimplemented and reserved bits read zero
  always_comb
  begin
    read_word = '0;
    unique case (dp_addr)
      osc_ctl_pkg::OFS_OSC_CONTROL:
      begin
        read_word[osc_ctl_pkg::BIT_SWITCH_REQ]  = switch_req;
        read_word[osc_ctl_pkg::BIT_SEC_OSC_EN]  = sec_osc_en;
        read_word[osc_ctl_pkg::BIT_CLOCK_FAIL]  = clock_fail;
        read_word[osc_ctl_pkg::BIT_CLOCK_LOCK]  = clock_lock;
        read_word[osc_ctl_pkg::NEW_SRC_LSB +: osc_ctl_pkg::SRC_BITS] = new_source;
        read_word[osc_ctl_pkg::CUR_SRC_LSB +: osc_ctl_pkg::SRC_BITS] = current_source;
      end
      osc_ctl_pkg::OFS_FAST_RC_TUNE:
        read_word[osc_ctl_pkg::TRIM_BITS-1:0] = trim;
      osc_ctl_pkg::OFS_WATCHDOG_CTL:
        read_word[osc_ctl_pkg::BIT_WATCHDOG_ON] = watchdog_run;
      osc_ctl_pkg::OFS_IRQ_FLAGS:
        read_word[osc_ctl_pkg::BIT_FAIL_IRQ] = fail_irq_flag;
      osc_ctl_pkg::OFS_IRQ_ENABLES:
        read_word[osc_ctl_pkg::BIT_FAIL_IRQ] = fail_irq_en;
      osc_ctl_pkg::OFS_IRQ_PRIORITY:
      begin
        read_word[osc_ctl_pkg::PRIO_LSB +: osc_ctl_pkg::PRIO_BITS]       = prio;
        read_word[osc_ctl_pkg::SUBPRIO_LSB +: osc_ctl_pkg::SUBPRIO_BITS] = subprio;
      end
      default:
        read_word = '0;                        // unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer; runs on the request bit, reports back on completion
  source_switch u_switch
  (
    .clk         (clk),
    .rst         (rst),
    .start       (switch_start),
    .target      (next_new_source),
    .boot_source (boot_cfg.source),
    .osc_ack     (osc_ack),
    .select      (mux_select),
    .current     (current_source),
    .busy        (switch_busy),
    .done        (switch_done)
  );

endmodule // osc_ctl

// ### design/osc_ctl_pkg.sv
// Purpose: shared constants and carriers for the oscillator control block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   offsets are byte addresses; only word accesses are meaningful
package osc_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_OSC_CONTROL  = 8'h00;  // oscillator_control
  localparam logic [7:0] OFS_FAST_RC_TUNE = 8'h04;  // fast_rc_tuning
  localparam logic [7:0] OFS_WATCHDOG_CTL = 8'h08;  // watchdog_control
  localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h0C;  // interrupt_flags_one
  localparam logic [7:0] OFS_IRQ_ENABLES  = 8'h10;  // interrupt_enables_one
  localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h14;  // interrupt_priority_eight
  localparam int         ADDR_BITS        = 8;      // decoded address width

  ////////////////////////////////////////////////////////////////////////////
  // oscillator_control field positions
  localparam int BIT_SWITCH_REQ   = 0;   // source_switch_request
  localparam int BIT_SEC_OSC_EN   = 1;   // secondary_osc_enable
  localparam int BIT_RESERVED_2   = 2;   // reserved, reads zero
  localparam int BIT_CLOCK_FAIL   = 3;   // clock_fail_flag
  localparam int BIT_CLOCK_LOCK   = 7;   // clock_select_lock
  localparam int NEW_SRC_LSB      = 8;   // new_source_select 10:8
  localparam int CUR_SRC_LSB      = 12;  // current source 14:12
  localparam int SRC_BITS         = 3;   // width of a source code

  // fast_rc_tuning
  localparam int TRIM_BITS        = 6;   // fast_rc_trim 5:0
  localparam logic [5:0] TRIM_RESET = 6'h00;  // calibrated center

  // watchdog_control
  localparam int BIT_WATCHDOG_ON  = 15;  // enable / running
  localparam int BIT_KICK         = 0;   // watchdog_kick, self clearing

  // interrupt registers
  localparam int BIT_FAIL_IRQ     = 14;  // flag and enable position
  localparam int PRIO_LSB         = 10;  // clock_fail_irq_priority 12:10
  localparam int PRIO_BITS        = 3;
  localparam int SUBPRIO_LSB      = 8;   // clock_fail_irq_subpriority 9:8
  localparam int SUBPRIO_BITS     = 2;
  localparam logic [2:0] PRIO_OFF = 3'h0;  // priority code that disables

  ////////////////////////////////////////////////////////////////////////////
  // clock source codes for new_source_select and current source
  typedef enum logic [2:0] {
    SRC_FAST_RC       = 3'h0,
    SRC_FAST_RC_PLL   = 3'h1,
    SRC_PRIMARY       = 3'h2,
    SRC_PRIMARY_PLL   = 3'h3,
    SRC_SECONDARY     = 3'h4,
    SRC_LOW_POWER_RC  = 3'h5,
    SRC_FAST_RC_DIV16 = 3'h6,
    SRC_FAST_RC_DIVN  = 3'h7
  } clk_source_e;

  // boot configuration straps, sampled while reset is held
  typedef struct packed {
    logic        fail_monitor_enable;  // monitor and lock are armed
    logic        watchdog_enable;      // watchdog forced on by boot
    clk_source_e source;               // source used out of reset
  } boot_cfg_s;

  // oscillator enables, mux select and trim handed to the analog side
  typedef struct packed {
    logic        secondary_osc_enable;
    logic        low_power_rc_enable;
    clk_source_e select;               // source requested of the mux
    logic [5:0]  fast_rc_trim;
  } osc_drive_s;

endpackage

// ### design/source_switch.sv
// Purpose: clock source switch sequencer
// Assumes: osc_ack pulses or holds high once the mux runs on the target
// Notes:   a start while busy is ignored; current source updates on ack
module source_switch
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // request side
  input  wire logic                      start,
  input  wire osc_ctl_pkg::clk_source_e  target,
  input  wire osc_ctl_pkg::clk_source_e  boot_source,
  // oscillator side
  input  wire logic                      osc_ack,
  output osc_ctl_pkg::clk_source_e       select,
  output osc_ctl_pkg::clk_source_e       current,
  output logic                           busy,
  output logic                           done
);

  ////////////////////////////////////////////////////////////////////////////
  // two-bit sequence: idle -> switching -> settle -> idle (00, 01, 11, 00)
  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_SWITCH = 2'b01,
    SW_SETTLE = 2'b11
  } switch_state_e;

  switch_state_e state;  // sequencer state

  // sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
      state <= SW_IDLE;
    else
    begin
      unique case (state)
        SW_IDLE:   if (start) state <= SW_SWITCH;    // begin change
        SW_SWITCH: if (osc_ack) state <= SW_SETTLE;  // mux has moved
        SW_SETTLE: state <= SW_IDLE;                 // one cycle to report
        default:   state <= SW_IDLE;                 // code 10 is illegal
      endcase
    end
  end

  // target latched at start so later field writes cannot disturb it
  always_ff @(posedge clk)
  begin
    if (rst)
      select <= boot_source;
    else if (state == SW_IDLE && start)
      select <= target;
  end

  // running source follows the mux only once it confirms
  always_ff @(posedge clk)
  begin
    if (rst)
      current <= boot_source;
    else if (state == SW_SWITCH && osc_ack)
      current <= select;
  end

  assign busy = (state != SW_IDLE);
  assign done = (state == SW_SETTLE);

endmodule // source_switch

// ### dv/osc_ctl_checker.sv
// Purpose: port-level timing checks for osc_ctl
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every osc_ctl instance below the module
module osc_ctl_checker
(
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // bus side
  input wire logic                      hsel,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  // device side
  input wire osc_ctl_pkg::boot_cfg_s    boot_cfg,
  input wire logic                      osc_ack,
  input wire osc_ctl_pkg::osc_drive_s   osc_drive,
  input wire osc_ctl_pkg::clk_source_e  current_source,
  input wire logic                      watchdog_run,
  input wire logic                      watchdog_restart,
  input wire logic                      irq,
  input wire logic [2:0]                irq_priority,
  input wire logic [1:0]                irq_subpriority
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  rc_clock_on_a:
    assert property (watchdog_run |-> osc_drive.low_power_rc_enable) else $error("rc clock off while watchdog runs");
  irq_prio_a:
    assert property (irq |-> irq_priority != osc_ctl_pkg::PRIO_OFF) else $error("irq with priority zero");
  kick_pulse_a:
    assert property (watchdog_restart |-> $past(hwdata[osc_ctl_pkg::BIT_KICK]))
    else $error("restart without kick");
  boot_watchdog_a:
    assert property ($past(rst) && $past(boot_cfg.watchdog_enable) |-> watchdog_run [*8])
    else $error("boot watchdog stopped");
  src_match_a:
    assert property ($changed(current_source) |-> current_source == osc_drive.select)
    else $error("source not selected");
  src_ack_a:
    assert property ($changed(current_source) |-> $past(osc_ack)) else $error("source changed without ack");
  prio_write_a:
    assert property ($changed({irq_priority, irq_subpriority}) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("priority changed without write");
  read_wait_a:
    assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule // osc_ctl_checker

bind osc_ctl osc_ctl_checker u_chk (.clk, .rst, .hsel, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .boot_cfg,
  .osc_ack, .osc_drive, .current_source, .watchdog_run, .watchdog_restart, .irq, .irq_priority, .irq_subpriority);

// ### dv/osc_ctl_test.sv
// Purpose: self-checking bench for osc_ctl over AHB-Lite
// Assumes: hready looped back from hreadyout, one clock
// Notes:   expected register images are kept per word index
module osc_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end

  logic                     clk, rst, hsel, hwrite, hready, hreadyout, hresp, clock_fail_detect, osc_ack;
  logic                     watchdog_run, watchdog_restart, irq, mon, bwdt;
  logic [31:0]              haddr, hwdata, hrdata, rd_q, seed;
  logic [31:0]              exp_reg [8];  // model images, 6 and 7 unmapped
  logic [1:0]               htrans, irq_subpriority;
  logic [2:0]               hsize, irq_priority;
  osc_ctl_pkg::boot_cfg_s   boot_cfg;
  osc_ctl_pkg::osc_drive_s  osc_drive;
  osc_ctl_pkg::clk_source_e current_source;
  int                       miscompares, compares;

  assign hready = hreadyout;  // single slave drives the bus ready

  osc_ctl u_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .boot_cfg, .clock_fail_detect, .osc_ack, .osc_drive, .current_source, .watchdog_run,
    .watchdog_restart, .irq, .irq_priority, .irq_subpriority);

  ////////////////////////////////////////////////////////////////////////////
  // xorshift, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ready looked at mid-cycle, where it has settled
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 50)
    begin
      miscompares++;
      end_sim();
    end
    rd_q = hrdata;
    @(posedge clk);
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  // write and update the model image
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    case (a[4:2])
      3'd0:
      begin
        if (!(mon && exp_reg[0][7])) exp_reg[0][10:8] = d[10:8];
        exp_reg[0][7] = d[7];
        exp_reg[0][3] = exp_reg[0][3] & d[3];
        exp_reg[0][1] = d[1];
      end
      3'd1: exp_reg[1] = d & 32'h3F;
      3'd2: exp_reg[2][15] = d[15] | bwdt;
      3'd3: exp_reg[3][14] = exp_reg[3][14] & ~d[14];
      3'd4: exp_reg[4] = d & 32'h4000;
      3'd5: exp_reg[5] = d & 32'h1F00;
      default: ;
    endcase
  endtask

  task automatic chk_rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    `CHK({hresp, rd_q}, {1'b0, exp_reg[a[4:2]]})
  endtask

  task automatic do_reset(input osc_ctl_pkg::boot_cfg_s b);
    boot_cfg <= b;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mon = b.fail_monitor_enable;
    bwdt = b.watchdog_enable;
    for (int k = 0; k < 8; k++) exp_reg[k] = '0;
    exp_reg[0][10:8] = b.source;
    exp_reg[0][14:12] = b.source;
    exp_reg[2][15] = bwdt;
  endtask

  // one-cycle failure from the monitor
  task automatic fail_event();
    @(posedge clk);
    clock_fail_detect <= 1'b1;
    @(posedge clk);
    clock_fail_detect <= 1'b0;
    exp_reg[0][3] = 1'b1;
    exp_reg[3][14] = 1'b1;
    @(negedge clk);
    `CHK(irq, exp_reg[4][14] & (exp_reg[5][12:10] != 3'h0))
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    int i, n;
    logic [31:0] v;
    {rst, hsel, hwrite, clock_fail_detect, osc_ack} = 5'h18;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    boot_cfg = '0;
    seed = 32'd28942;
    {miscompares, compares} = '0;
    do_reset({1'b0, 1'b0, osc_ctl_pkg::SRC_FAST_RC_DIV16});
    for (i = 0; i < 8; i++) chk_rd(8'(i * 4));
    $display("test reset done");
    // trim: centre, maximum, minimum, random; garbage above
    for (i = 0; i < 4; i++)
    begin
      v = rnd();
      v[5:0] = (i == 0) ? 6'h00 : (i == 1) ? 6'h1F : (i == 2) ? 6'h20 : v[5:0];
      wr(8'h04, v);
      chk_rd(8'h04);
      `CHK(osc_drive.fast_rc_trim, v[5:0])
    end
    $display("test trim done");
    wr(8'h08, 32'h8000);
    @(negedge clk);
    `CHK({watchdog_run, osc_drive.low_power_rc_enable}, 2'h3)
    chk_rd(8'h08);
    wr(8'h08, 32'h0);
    @(negedge clk);
    `CHK(watchdog_run, 1'b0)
    wr(8'h08, 32'h1);
    @(negedge clk);
    `CHK(watchdog_restart, 1'b1)
    chk_rd(8'h08);
    $display("test watchdog done");
    // every priority code, then the enable taken away
    wr(8'h10, 32'h4000);
    for (i = 0; i < 9; i++)
    begin
      if (i == 8) wr(8'h10, 32'h0);
      v = {19'h0, i[2:0], i[1:0], 8'h0};
      wr(8'h14, v);
      @(negedge clk);
      `CHK({irq_priority, irq_subpriority}, v[12:8])
      fail_event();
      chk_rd(8'h00);
      chk_rd(8'h0C);
      wr(8'h0C, 32'h4000);
      wr(8'h00, exp_reg[0] & 32'h0782);
      @(negedge clk);
      `CHK(irq, 1'b0)
    end
    $display("test interrupt done");
    // every source code, secondary oscillator toggled along
    for (i = 0; i < 8; i++)
    begin
      wr(8'h00, {21'h0, i[2:0], 6'h0, i[0], 1'b1});
      @(negedge clk);
      `CHK({osc_drive.select, osc_drive.secondary_osc_enable}, {i[2:0], i[0]})
      repeat (1 + rnd() % 4) @(posedge clk);
      osc_ack <= 1'b1;
      n = 0;
      do
      begin
        bus(1'b0, 8'h00, 32'h0);
        n++;
      end
      while (rd_q[0] !== 1'b0 && n < 20);
      if (rd_q[0] !== 1'b0)
      begin
        miscompares++;
        end_sim();
      end
      osc_ack <= 1'b0;
      exp_reg[0][14:12] = i[2:0];
      chk_rd(8'h00);
      `CHK(current_source, i[2:0])
    end
    $display("test switch done");
    do_reset({1'b1, 1'b1, osc_ctl_pkg::SRC_PRIMARY});
    chk_rd(8'h08);
    wr(8'h08, 32'h0);
    @(negedge clk);
    `CHK(watchdog_run, 1'b1)
    wr(8'h00, 32'h0280);
    wr(8'h00, 32'h0581);
    chk_rd(8'h00);
    `CHK(osc_drive.select, osc_ctl_pkg::SRC_PRIMARY)
    $display("test lock done");
    end_sim();
  end
endmodule // osc_ctl_test
